/* File: hdl/gdt_watchdog.sv */
// Windowed guard timer: registers, service, prewarning and chip reset request
`timescale 1ns/1ps
`default_nettype none
`include "gdt_params.svh"

module gdt_watchdog (
  input wire logic clk_sys, // System clock, 200 MHz
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic osc_75k, // 75 kHz oscillator pin
  input wire logic [3:0] system_page_select, // Active special-function page
  input wire logic [7:0] sfr_addr, // Register address
  input wire logic [7:0] sfr_wdata, // Write data
  input wire logic sfr_wr, // Write strobe
  input wire logic sfr_rd, // Read strobe
  output logic [7:0] sfr_rdata, // Read data, one cycle after strobe
  input wire logic debug_suspend, // Debugger suspend request
  input wire logic guard_suspend, // Suspend bit of module suspend control
  input wire logic guard_nmi_enable, // NMI node enable
  input wire logic nmi_flag_clr, // NMI node flag clear pulse
  output logic guard_nmi_flag, // NMI node flag
  output logic nmi_req, // NMI request to the NMI controller
  output logic [7:0] nmi_vector, // Vector of this NMI node
  output logic chip_reset_req, // Chip reset request pulse
  output logic prewarn_flag // Prewarning active
);
  gdt_cnt_if cif ();

  gdt_tick_sync #(
    .STAGES(3)
  ) u_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .osc_75k(osc_75k),
    .cif(cif)
  );

  gdt_counter u_cnt (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .cif(cif)
  );

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  gdt_pkg::gdt_state_e state;
  logic [7:0] reload_high_byte;
  logic [7:0] window_boundary;
  logic guard_enable;
  logic refresh_start;
  logic window_enable;
  logic guard_reset_indication;
  logic [5:0] prewarn_cnt;

  function automatic logic sfr_sel(input logic [3:0] pg, input logic [7:0] ad,
                                   input logic [3:0] want_pg, input logic [7:0] want_ad);
    sfr_sel = (pg == want_pg) && (ad == want_ad);
  endfunction

  logic wr_reload;
  logic wr_window;
  logic wr_ctrl;
  logic wr_rstctl;
  logic start_en;
  logic service;
  logic in_window;
  logic svc_ok;
  logic svc_bad;
  logic halt;
  logic prewarn_end;
  logic guard_reset;
  logic enter_prewarn;

  assign wr_reload = sfr_wr && sfr_sel(system_page_select, sfr_addr, `GDT_PAGE_TMR,
                                       `GDT_ADDR_RELOAD);
  assign wr_window = sfr_wr && sfr_sel(system_page_select, sfr_addr, `GDT_PAGE_TMR,
                                       `GDT_ADDR_WINDOW);
  assign wr_ctrl = sfr_wr && sfr_sel(system_page_select, sfr_addr, `GDT_PAGE_SYS,
                                     `GDT_ADDR_CTRL);
  assign wr_rstctl = sfr_wr && sfr_sel(system_page_select, sfr_addr, `GDT_PAGE_SYS,
                                       `GDT_ADDR_RSTCTL);

  // ----------------------------------------------------------------
  // Service and error decisions
  // ----------------------------------------------------------------
  assign start_en = (state == gdt_pkg::GDT_OFF) && guard_enable;
  assign service = refresh_start && (state == gdt_pkg::GDT_RUN);
  assign in_window = (cif.count <= {window_boundary, `GDT_LOW_ZERO});
  assign svc_bad = service && window_enable && in_window;
  assign svc_ok = service && !svc_bad;
  assign halt = debug_suspend && guard_suspend;
  assign enter_prewarn = (state == gdt_pkg::GDT_RUN) && guard_enable && cif.ovf && !service;
  assign prewarn_end = (state == gdt_pkg::GDT_PREWARN) && cif.tick && !halt
                       && (prewarn_cnt == `GDT_PREWARN_TICKS - 6'h01);
  assign guard_reset = svc_bad || prewarn_end;

  assign cif.run = (state == gdt_pkg::GDT_RUN) && !halt;
  assign cif.load = start_en || svc_ok;
  assign cif.load_val = {reload_high_byte, `GDT_LOW_ZERO};

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      guard_enable <= 1'b0;
      window_enable <= 1'b0;
    end else if (guard_reset) begin
      // The chip reset that follows brings the timer back to disabled
      guard_enable <= 1'b0;
      window_enable <= 1'b0;
    end else if (wr_ctrl) begin
      window_enable <= sfr_wdata[`GDT_CTRL_WINEN];
      if (!(prewarn_flag && !sfr_wdata[`GDT_CTRL_EN])) begin
        guard_enable <= sfr_wdata[`GDT_CTRL_EN];
      end
    end
  end

  // Refresh bit: a fresh write of one wins over the automatic clear
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      refresh_start <= 1'b0;
    end else if (wr_ctrl && sfr_wdata[`GDT_CTRL_RS]) begin
      refresh_start <= 1'b1;
    end else begin
      refresh_start <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reload_high_byte <= `GDT_RELOAD_RST;
      window_boundary <= `GDT_WINDOW_RST;
    end else begin
      if (wr_reload) begin
        reload_high_byte <= sfr_wdata;
      end
      if (wr_window) begin
        window_boundary <= sfr_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= gdt_pkg::GDT_OFF;
    end else begin
      case (state)
        gdt_pkg::GDT_OFF: begin
          if (guard_enable) begin
            state <= gdt_pkg::GDT_RUN;
          end
        end
        gdt_pkg::GDT_RUN: begin
          if (guard_reset || !guard_enable) begin
            state <= gdt_pkg::GDT_OFF;
          end else if (enter_prewarn) begin
            state <= gdt_pkg::GDT_PREWARN;
          end
        end
        gdt_pkg::GDT_PREWARN: begin
          if (prewarn_end) begin
            state <= gdt_pkg::GDT_OFF;
          end
        end
        default: begin
          state <= gdt_pkg::GDT_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prewarn_cnt <= '0;
    end else if (state != gdt_pkg::GDT_PREWARN) begin
      prewarn_cnt <= '0;
    end else if (cif.tick && !halt) begin
      prewarn_cnt <= prewarn_cnt + 6'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prewarn_flag <= 1'b0;
    end else if (enter_prewarn) begin
      prewarn_flag <= 1'b1;
    end else if (prewarn_end) begin
      prewarn_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Reset request and its indication
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      chip_reset_req <= 1'b0;
    end else begin
      chip_reset_req <= guard_reset;
    end
  end

  // Kept across the chip reset this block requests; arst_n or a write of zero to its bit clears it
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      guard_reset_indication <= 1'b0;
    end else if (guard_reset) begin
      guard_reset_indication <= 1'b1;
    end else if (wr_rstctl && !sfr_wdata[`GDT_RST_IND]) begin
      guard_reset_indication <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // NMI node
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      guard_nmi_flag <= 1'b0;
      nmi_req <= 1'b0;
      nmi_vector <= `GDT_NMI_VECTOR;
    end else begin
      if (enter_prewarn) begin
        guard_nmi_flag <= 1'b1;
      end else if (nmi_flag_clr) begin
        guard_nmi_flag <= 1'b0;
      end
      nmi_req <= guard_nmi_flag && guard_nmi_enable;
      nmi_vector <= `GDT_NMI_VECTOR;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata <= 8'h00;
      if (sfr_sel(system_page_select, sfr_addr, `GDT_PAGE_TMR, `GDT_ADDR_RELOAD)) begin
        sfr_rdata <= reload_high_byte;
      end
      if (sfr_sel(system_page_select, sfr_addr, `GDT_PAGE_TMR, `GDT_ADDR_WINDOW)) begin
        sfr_rdata <= window_boundary;
      end
      if (sfr_sel(system_page_select, sfr_addr, `GDT_PAGE_TMR, `GDT_ADDR_CNT_LO)) begin
        sfr_rdata <= cif.count[7:0];
      end
      if (sfr_sel(system_page_select, sfr_addr, `GDT_PAGE_TMR, `GDT_ADDR_CNT_HI)) begin
        sfr_rdata <= cif.count[15:8];
      end
      if (sfr_sel(system_page_select, sfr_addr, `GDT_PAGE_SYS, `GDT_ADDR_CTRL)) begin
        sfr_rdata[`GDT_CTRL_RS] <= refresh_start;
        sfr_rdata[`GDT_CTRL_EN] <= guard_enable;
        sfr_rdata[`GDT_CTRL_PR] <= prewarn_flag;
        sfr_rdata[`GDT_CTRL_WINEN] <= window_enable;
      end
      if (sfr_sel(system_page_select, sfr_addr, `GDT_PAGE_SYS, `GDT_ADDR_RSTCTL)) begin
        // Other reset sources live elsewhere; their bits and 6..3 read zero
        sfr_rdata[`GDT_RST_IND] <= guard_reset_indication;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  logic rd_rstctl;
  assign rd_rstctl = sfr_rd && sfr_sel(system_page_select, sfr_addr, `GDT_PAGE_SYS,
                                       `GDT_ADDR_RSTCTL);

  sequence s_overflow_hit;
    (state == gdt_pkg::GDT_RUN) && guard_enable && cif.ovf && !refresh_start;
  endsequence

  sequence s_prewarn_entered;
    prewarn_flag && guard_nmi_flag && (state == gdt_pkg::GDT_PREWARN);
  endsequence

  a_overflow_to_prewarn: assert property (s_overflow_hit |=> s_prewarn_entered)
    else $error("overflow did not enter prewarning");

  a_refresh_self_clear: assert property (
    refresh_start && !(wr_ctrl && sfr_wdata[`GDT_CTRL_RS]) |=> !refresh_start)
    else $error("refresh bit did not clear");

  a_service_reload: assert property (
    svc_ok |=> cif.count == {$past(reload_high_byte), `GDT_LOW_ZERO})
    else $error("service did not reload counter");

  a_start_load: assert property (
    $rose(guard_enable) && (state == gdt_pkg::GDT_OFF)
    |=> (cif.count == {$past(reload_high_byte), `GDT_LOW_ZERO})
        && (state == gdt_pkg::GDT_RUN))
    else $error("enable did not load start value");

  a_refresh_beats_ovf: assert property (
    (state == gdt_pkg::GDT_RUN) && cif.tick && !halt && svc_ok
    && (cif.count == `GDT_CNT_ALL_ONES) |=> !prewarn_flag && !$rose(guard_nmi_flag))
    else $error("refresh at overflow entered prewarning");

  a_prewarn_holds: assert property (
    prewarn_flag && wr_ctrl && !sfr_wdata[`GDT_CTRL_EN] && !prewarn_end
    |=> guard_enable && (state == gdt_pkg::GDT_PREWARN))
    else $error("disable took effect in prewarning");

  a_prewarn_no_refresh: assert property (
    prewarn_flag && refresh_start && !prewarn_end |=> $stable(cif.count) && prewarn_flag)
    else $error("refresh acted in prewarning");

  a_window_reset: assert property (
    svc_bad |=> chip_reset_req && guard_reset_indication && !prewarn_flag
                && !$rose(guard_nmi_flag))
    else $error("invalid refresh did not reset without NMI");

  a_prewarn_length: assert property (
    (state == gdt_pkg::GDT_PREWARN) && cif.tick && !halt
    && (prewarn_cnt == `GDT_PREWARN_TICKS - 6'h01)
    |=> chip_reset_req && guard_reset_indication && !prewarn_flag)
    else $error("prewarning did not end in reset");

  a_reset_only_cause: assert property (
    $rose(chip_reset_req) |-> $past(svc_bad) || $past(prewarn_end))
    else $error("reset request without cause");

  a_debug_halt: assert property (
    halt && !cif.load |=> $stable(cif.count))
    else $error("counter moved while suspended");

  a_rstctl_zero: assert property (
    rd_rstctl |=> sfr_rdata[6:3] == 4'h0
                  && sfr_rdata[`GDT_RST_IND] == $past(guard_reset_indication))
    else $error("reset control readback wrong");

  a_nmi_gate: assert property (
    guard_nmi_flag && guard_nmi_enable |=> nmi_req)
    else $error("NMI request not raised");

endmodule // gdt_watchdog

`default_nettype wire

/* File: hdl/gdt_params.svh */
// Constants of the windowed guard timer: offsets, field positions, reset values, counts
`ifndef GDT_PARAMS_SVH
`define GDT_PARAMS_SVH

// ----------------------------------------------------------------
// Pages and offsets
// ----------------------------------------------------------------
`define GDT_PAGE_SYS 4'h1
`define GDT_PAGE_TMR 4'h4
`define GDT_ADDR_RELOAD 8'hf3
`define GDT_ADDR_WINDOW 8'hf4
`define GDT_ADDR_CNT_LO 8'hf5
`define GDT_ADDR_CTRL 8'hf6
`define GDT_ADDR_CNT_HI 8'hf6
`define GDT_ADDR_RSTCTL 8'hf7

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define GDT_CTRL_RS 1
`define GDT_CTRL_EN 2
`define GDT_CTRL_PR 4
`define GDT_CTRL_WINEN 5
`define GDT_RST_IND 1

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define GDT_RELOAD_RST 8'h00
`define GDT_WINDOW_RST 8'h00
`define GDT_RSTCTL_AFTER_GUARD 8'h02
`define GDT_PREWARN_TICKS 6'h30
`define GDT_NMI_VECTOR 8'h73
`define GDT_CNT_ALL_ONES 16'hffff
`define GDT_LOW_ZERO 8'h00

`endif

/* File: hdl/gdt_pkg.sv */
// Types shared by the guard timer modules
package gdt_pkg;

  typedef enum logic [1:0] {
    GDT_OFF,
    GDT_RUN,
    GDT_PREWARN
  } gdt_state_e;

endpackage

/* File: hdl/gdt_cnt_if.sv */
// Signals between the guard timer control, its tick synchroniser and its counter
`timescale 1ns/1ps
`default_nettype none

interface gdt_cnt_if;
  logic tick;
  logic run;
  logic load;
  logic [15:0] load_val;
  logic [15:0] count;
  logic ovf;
  modport src (output tick);
  modport cnt (input tick, input run, input load, input load_val, output count, output ovf);
  modport ctl (input tick, input count, input ovf, output run, output load, output load_val);
endinterface // gdt_cnt_if

`default_nettype wire

/* File: hdl/gdt_tick_sync.sv */
// Brings the 75 kHz oscillator into clk_sys and makes one tick per oscillator period
`timescale 1ns/1ps
`default_nettype none

module gdt_tick_sync #(
  parameter int STAGES = 3
) (
  input wire logic clk_sys, // System clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic osc_75k, // Oscillator pin, asynchronous
  gdt_cnt_if.src cif // Tick out
);
  logic [STAGES-1:0] sync;
  logic stable;

  // ----------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync <= '0;
    end else begin
      sync <= {sync[STAGES-2:0], osc_75k};
    end
  end

  // A level is taken only when the last two stages agree
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stable <= 1'b0;
      cif.tick <= 1'b0;
    end else begin
      if (sync[STAGES-1] == sync[STAGES-2]) begin
        stable <= sync[STAGES-1];
      end
      cif.tick <= (sync[STAGES-1] == sync[STAGES-2]) && sync[STAGES-1] && !stable;
    end
  end
endmodule // gdt_tick_sync

`default_nettype wire

/* File: hdl/gdt_counter.sv */
// Sixteen-bit up counter made of two cascaded byte halves
`timescale 1ns/1ps
`default_nettype none
`include "gdt_params.svh"

module gdt_counter (
  input wire logic clk_sys, // System clock
  input wire logic arst_n, // Asynchronous reset, active low
  gdt_cnt_if.cnt cif // Count, load and overflow
);
  logic [7:0] low;
  logic [7:0] high;
  logic carry;

  assign carry = &low;
  assign cif.count = {high, low};
  // Overflow is held off by a load in the same cycle, so a service wins
  assign cif.ovf = cif.tick && cif.run && !cif.load && (cif.count == `GDT_CNT_ALL_ONES);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      low <= `GDT_LOW_ZERO;
      high <= `GDT_LOW_ZERO;
    end else if (cif.load) begin
      low <= cif.load_val[7:0];
      high <= cif.load_val[15:8];
    end else if (cif.tick && cif.run) begin
      low <= low + 8'h01;
      if (carry) begin
        high <= high + 8'h01;
      end
    end
  end
endmodule // gdt_counter

`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the windowed guard timer
`timescale 1ns/1ps
`default_nettype none
`include "gdt_params.svh"

module testbench;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic osc_75k = 1'b0;
  logic [3:0] pg = 4'h0;
  logic [7:0] ad = 8'h00;
  logic [7:0] wd = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic dbg = 1'b0;
  logic gsusp = 1'b1;
  logic nmi_en = 1'b1;
  logic nmi_clr = 1'b0;
  logic [7:0] rdata;
  logic [7:0] vec;
  logic nmi_flag;
  logic nmi_req;
  logic rst_req;
  logic prewarn;
  int fails = 0;
  int n_compared = 0;
  int seed = 26;
  int cyc = 0;
  int n_rst = 0;
  int n;
  int t0;
  logic [7:0] r8;
  logic [7:0] r8b;
  logic [15:0] c0;
  logic [15:0] c1;

  gdt_watchdog i_dut (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .osc_75k(osc_75k),
    .system_page_select(pg),
    .sfr_addr(ad),
    .sfr_wdata(wd),
    .sfr_wr(wr),
    .sfr_rd(rd),
    .sfr_rdata(rdata),
    .debug_suspend(dbg),
    .guard_suspend(gsusp),
    .guard_nmi_enable(nmi_en),
    .nmi_flag_clr(nmi_clr),
    .guard_nmi_flag(nmi_flag),
    .nmi_req(nmi_req),
    .nmi_vector(vec),
    .chip_reset_req(rst_req),
    .prewarn_flag(prewarn)
  );

  // ----------------------------------------------------------------
  // Clocks, pulse counter and hang limit
  // ----------------------------------------------------------------
  initial forever #2.5 clk_sys = ~clk_sys;
  // Oscillator kept unrelated to clk_sys and far faster than real, yet above the 4-cycle floor
  initial forever #27 osc_75k = ~osc_75k;

  always @(posedge clk_sys) begin
    cyc++;
    if (rst_req === 1'b1) n_rst++;
    if (cyc == 40000) begin
      fails++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] start_val(input logic [7:0] rel);
    return {rel, 8'h00};
  endfunction

  function automatic logic win_bad(input logic [15:0] cnt, input logic [7:0] win);
    return cnt <= {win, 8'h00};
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, seen);
      fails++;
    end
  endtask

  task automatic wr_reg(input logic [3:0] p, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    pg = p;
    ad = a;
    wd = d;
    wr = 1'b1;
    @(posedge clk_sys);
    #1;
    wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] p, input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1;
    pg = p;
    ad = a;
    rd = 1'b1;
    @(posedge clk_sys);
    #1;
    rd = 1'b0;
    d = rdata;
  endtask

  task automatic rd_chk(input string what, input logic [3:0] p, input logic [7:0] a,
                        input logic [7:0] exp);
    logic [7:0] d;
    rd_reg(p, a, d);
    check(what, {8'h00, d}, {8'h00, exp});
  endtask

  // Low byte first; callers allow for a carry between the two reads
  task automatic cnt_rd(output logic [15:0] c);
    rd_reg(`GDT_PAGE_TMR, `GDT_ADDR_CNT_LO, c[7:0]);
    rd_reg(`GDT_PAGE_TMR, `GDT_ADDR_CNT_HI, c[15:8]);
  endtask

  task automatic give_verdict();
    if (fails == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    check("nmi_vector", {8'h00, vec}, {8'h00, `GDT_NMI_VECTOR});
    check("prewarn_flag", {15'h0, prewarn}, 16'h0000);
    rd_chk("reload", `GDT_PAGE_TMR, `GDT_ADDR_RELOAD, 8'h00);
    rd_chk("window", `GDT_PAGE_TMR, `GDT_ADDR_WINDOW, 8'h00);
    rd_chk("control", `GDT_PAGE_SYS, `GDT_ADDR_CTRL, 8'h00);
    rd_chk("reset_control", `GDT_PAGE_SYS, `GDT_ADDR_RSTCTL, 8'h00);
    rd_chk("unmapped_a", `GDT_PAGE_TMR, 8'hf7, 8'h00);
    rd_chk("unmapped_b", 4'h2, 8'hf6, 8'h00);
    // Random register traffic; counts must ignore writes while the timer is off
    for (int i = 0; i < 6; i++) begin
      r8 = 8'($random(seed));
      r8b = 8'($random(seed));
      wr_reg(`GDT_PAGE_TMR, `GDT_ADDR_RELOAD, r8);
      wr_reg(`GDT_PAGE_TMR, `GDT_ADDR_WINDOW, r8b);
      wr_reg(`GDT_PAGE_TMR, `GDT_ADDR_CNT_LO, r8b);
      rd_chk("reload", `GDT_PAGE_TMR, `GDT_ADDR_RELOAD, r8);
      rd_chk("window", `GDT_PAGE_TMR, `GDT_ADDR_WINDOW, r8b);
      rd_chk("count_low", `GDT_PAGE_TMR, `GDT_ADDR_CNT_LO, 8'h00);
    end
    // Debug suspend halts the count unless the suspend bit is cleared
    wr_reg(`GDT_PAGE_TMR, `GDT_ADDR_RELOAD, 8'h10);
    wr_reg(`GDT_PAGE_SYS, `GDT_ADDR_CTRL, 8'h04);
    dbg = 1'b1;
    repeat (30) @(posedge clk_sys);
    cnt_rd(c0);
    check("start_value", c0, start_val(8'h10));
    repeat (300) @(posedge clk_sys);
    cnt_rd(c1);
    check("count_halted", c1, c0);
    gsusp = 1'b0;
    repeat (300) @(posedge clk_sys);
    cnt_rd(c1);
    check("count_runs", {15'h0, c1 > c0}, 16'h0001);
    dbg = 1'b0;
    gsusp = 1'b1;
    // Service reloads from a freshly written reload and clears the refresh bit
    wr_reg(`GDT_PAGE_SYS, `GDT_ADDR_CTRL, 8'h00);
    wr_reg(`GDT_PAGE_TMR, `GDT_ADDR_RELOAD, 8'hc0);
    wr_reg(`GDT_PAGE_SYS, `GDT_ADDR_CTRL, 8'h04);
    repeat (200) @(posedge clk_sys);
    cnt_rd(c0);
    check("count_up", {15'h0, c0 > start_val(8'hc0)}, 16'h0001);
    wr_reg(`GDT_PAGE_TMR, `GDT_ADDR_RELOAD, 8'hc8);
    wr_reg(`GDT_PAGE_SYS, `GDT_ADDR_CTRL, 8'h06);
    rd_chk("refresh_cleared", `GDT_PAGE_SYS, `GDT_ADDR_CTRL, 8'h04);
    cnt_rd(c1);
    check("serviced_high", {8'h00, c1[15:8]}, 16'h00c8);
    check("serviced_low", {15'h0, c1[7:0] <= 8'h01}, 16'h0001);
    // Early refresh is harmless with the window off, fatal with it on
    wr_reg(`GDT_PAGE_TMR, `GDT_ADDR_WINDOW, 8'hff);
    n = n_rst;
    wr_reg(`GDT_PAGE_SYS, `GDT_ADDR_CTRL, 8'h06);
    repeat (6) @(posedge clk_sys);
    check("no_window_reset", 16'(n_rst - n), 16'h0000);
    wr_reg(`GDT_PAGE_SYS, `GDT_ADDR_CTRL, 8'h24);
    wr_reg(`GDT_PAGE_SYS, `GDT_ADDR_CTRL, 8'h26);
    repeat (6) @(posedge clk_sys);
    check("window_reset", 16'(n_rst - n), {15'h0, win_bad(start_val(8'hc8), 8'hff)});
    check("window_no_nmi", {15'h0, nmi_flag}, 16'h0000);
    rd_chk("reset_ind", `GDT_PAGE_SYS, `GDT_ADDR_RSTCTL, `GDT_RSTCTL_AFTER_GUARD);
    rd_chk("ctrl_after_rst", `GDT_PAGE_SYS, `GDT_ADDR_CTRL, 8'h00);
    // Only a write of zero or arst_n clears the indication, and reserved bits stay zero
    wr_reg(`GDT_PAGE_SYS, `GDT_ADDR_RSTCTL, 8'hff);
    rd_chk("rstctl_ones", `GDT_PAGE_SYS, `GDT_ADDR_RSTCTL, 8'h02);
    wr_reg(`GDT_PAGE_SYS, `GDT_ADDR_RSTCTL, 8'h00);
    rd_chk("rstctl_clear", `GDT_PAGE_SYS, `GDT_ADDR_RSTCTL, 8'h00);
    wr_reg(`GDT_PAGE_SYS, `GDT_ADDR_RSTCTL, 8'hff);
    rd_chk("rstctl_no_set", `GDT_PAGE_SYS, `GDT_ADDR_RSTCTL, 8'h00);
    // Unserviced overflow, prewarning, then the chip reset request
    wr_reg(`GDT_PAGE_TMR, `GDT_ADDR_RELOAD, 8'hff);
    wr_reg(`GDT_PAGE_SYS, `GDT_ADDR_CTRL, 8'h04);
    n = 0;
    while (prewarn !== 1'b1 && n < 4000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    t0 = cyc;
    check("prewarn_set", {15'h0, prewarn}, 16'h0001);
    check("nmi_flag_set", {15'h0, nmi_flag}, 16'h0001);
    @(posedge clk_sys);
    #1;
    check("nmi_req", {15'h0, nmi_req}, 16'h0001);
    nmi_en = 1'b0;
    @(posedge clk_sys);
    #1;
    check("nmi_req_gated", {15'h0, nmi_req}, 16'h0000);
    nmi_en = 1'b1;
    rd_chk("ctrl_prewarn", `GDT_PAGE_SYS, `GDT_ADDR_CTRL, 8'h14);
    wr_reg(`GDT_PAGE_SYS, `GDT_ADDR_CTRL, 8'h00);
    rd_chk("disable_ignored", `GDT_PAGE_SYS, `GDT_ADDR_CTRL, 8'h14);
    wr_reg(`GDT_PAGE_SYS, `GDT_ADDR_CTRL, 8'h06);
    check("refresh_ignored", {15'h0, prewarn}, 16'h0001);
    n = 0;
    while (rst_req !== 1'b1 && n < 700) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    // 48 oscillator periods of 54 ns in 5 ns cycles, give or take one period
    check("prewarn_len", {15'h0, (cyc - t0) >= 505 && (cyc - t0) <= 531}, 16'h0001);
    check("prewarn_end", {15'h0, prewarn}, 16'h0000);
    rd_chk("rstctl_guard", `GDT_PAGE_SYS, `GDT_ADDR_RSTCTL, `GDT_RSTCTL_AFTER_GUARD);
    rd_chk("ctrl_off", `GDT_PAGE_SYS, `GDT_ADDR_CTRL, 8'h00);
    @(posedge clk_sys);
    #1;
    nmi_clr = 1'b1;
    @(posedge clk_sys);
    #1;
    nmi_clr = 1'b0;
    check("nmi_flag_clr", {15'h0, nmi_flag}, 16'h0000);
    give_verdict();
  end
endmodule // testbench

`default_nettype wire
